// *** inc/icl_pkg.sv ***
// types shared by the interval counter design
`default_nettype none
package icl_pkg;
  typedef struct packed {
    logic [1:0] rw;
    logic [2:0] mode;
    logic bcd;
  } icl_ctrl_t;
  typedef struct packed {
    logic out;
    logic null_count;
    icl_ctrl_t ctrl;
  } icl_status_t;
  typedef enum logic [2:0] {
    ICL_RD_TRANSP = 3'b001,
    ICL_RD_LOW = 3'b010,
    ICL_RD_HIGH = 3'b100
  } icl_rdstate_t;
endpackage
`default_nettype wire

// *** inc/icl_regs.svh ***
// register offsets, field positions and field codes of the interval counter
`ifndef ICL_REGS_SVH
`define ICL_REGS_SVH
`define ICL_PORT_CNT0 2'h0
`define ICL_PORT_CNT1 2'h1
`define ICL_PORT_CNT2 2'h2
`define ICL_PORT_CTRL 2'h3
`define ICL_SEL_HI 7
`define ICL_SEL_LO 6
`define ICL_RW_HI 5
`define ICL_RW_LO 4
`define ICL_RB_COUNT_N 5
`define ICL_RB_STATUS_N 4
`define ICL_RB_MASK_HI 3
`define ICL_RB_MASK_LO 1
`define ICL_SEL_READBACK 2'h3
`define ICL_RW_LATCH 2'h0
`define ICL_RW_LSB 2'h1
`define ICL_RW_MSB 2'h2
`define ICL_RW_WORD 2'h3
`define ICL_MODE_IOC 3'h0
`define ICL_MODE_ONESHOT 3'h1
`define ICL_NCOUNTERS 3
`endif

// *** rtl/icl_timer.sv ***
// three-counter interval timer with latch, read-back, modes 0 and 1
`timescale 1ns/1ps
`default_nettype none
`include "icl_regs.svh"
module icl_timer
  import icl_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic timer_tick_input,
  input wire logic [2:0] counter_gate_input,
  output logic [2:0] counter_output_pin
);
  // ************************************************************
  // per-counter state, plus the shared tick delay and read data
  // ************************************************************
  localparam int N = `ICL_NCOUNTERS;
  icl_ctrl_t ctrl [N];
  icl_ctrl_t next_ctrl [N];
  logic [15:0] ce [N], next_ce [N];
  logic [15:0] cil [N], next_cil [N];
  logic [15:0] ol [N], next_ol [N];
  logic [N-1:0] ol_held, next_ol_held;
  logic [7:0] st_lat [N], next_st_lat [N];
  logic [N-1:0] st_held, next_st_held;
  icl_rdstate_t rd_st [N], next_rd_st [N];
  logic [N-1:0] wr_low_done, next_wr_low_done;
  logic [N-1:0] load_pend, next_load_pend;
  logic [N-1:0] armed, next_armed;
  logic [N-1:0] nullc, next_nullc;
  logic [N-1:0] outp, next_outp;
  logic [N-1:0] trig, next_trig;
  logic [N-1:0] trig_smp, next_trig_smp;
  logic [N-1:0] gate_d, next_gate_d;
  logic [N-1:0] gate_smp, next_gate_smp;
  logic tick_d, next_tick_d;
  logic [7:0] next_rdata;

  function automatic logic [7:0] status_byte(input logic o, input logic nc, input icl_ctrl_t c);
    status_byte = {o, nc, c};
  endfunction

  function automatic logic [15:0] dec16(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    r = v - 16'h0001;
    // bcd: borrow per digit, zero wraps to 9999
    if (bcd) begin
      for (int d = 0; d < 4; d++) begin
        if (r[d*4 +: 4] > 4'h9) begin
          r[d*4 +: 4] = r[d*4 +: 4] - 4'h6;
        end
      end
    end
    dec16 = r;
  endfunction

  wire tick_rise = timer_tick_input && !tick_d;
  wire tick_fall = !timer_tick_input && tick_d;
  wire ctrl_wr = io_wr && (io_addr == `ICL_PORT_CTRL);
  wire [1:0] sel = io_wdata[`ICL_SEL_HI:`ICL_SEL_LO];
  wire is_rb = (sel == `ICL_SEL_READBACK);
  wire [2:0] rb_mask = io_wdata[`ICL_RB_MASK_HI:`ICL_RB_MASK_LO];

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    next_tick_d = timer_tick_input;
    next_rdata = io_rdata;
    for (int i = 0; i < N; i++) begin
      next_ctrl[i] = ctrl[i];
      next_ce[i] = ce[i];
      next_cil[i] = cil[i];
      next_ol[i] = ol_held[i] ? ol[i] : ce[i];
      next_ol_held[i] = ol_held[i];
      next_st_lat[i] = st_lat[i];
      next_st_held[i] = st_held[i];
      next_rd_st[i] = rd_st[i];
      next_wr_low_done[i] = wr_low_done[i];
      next_load_pend[i] = load_pend[i];
      next_armed[i] = armed[i];
      next_nullc[i] = nullc[i];
      next_outp[i] = outp[i];
      next_gate_d[i] = counter_gate_input[i];
      next_trig[i] = trig[i] || (counter_gate_input[i] && !gate_d[i]);
      next_trig_smp[i] = trig_smp[i];
      next_gate_smp[i] = gate_smp[i];
      // gate sampled on tick rise; edge flag cleared once sampled
      if (tick_rise) begin
        next_gate_smp[i] = counter_gate_input[i];
        next_trig_smp[i] = trig[i] || (counter_gate_input[i] && !gate_d[i]);
        next_trig[i] = 1'b0;
      end

      // counting element on the falling half of a tick
      // placed before the host paths so a same-cycle write or control word wins
      if (tick_fall) begin
        if (ctrl[i].mode == `ICL_MODE_ONESHOT) begin
          if (load_pend[i]) begin
            next_armed[i] = 1'b1;
            next_load_pend[i] = 1'b0;
          end
          if (trig_smp[i] && (armed[i] || load_pend[i])) begin
            next_ce[i] = cil[i];
            next_nullc[i] = 1'b0;
            next_outp[i] = 1'b0;
          end else if (!outp[i]) begin
            next_ce[i] = dec16(ce[i], ctrl[i].bcd);
            if (ce[i] == 16'h0001) begin
              next_outp[i] = 1'b1;
            end
          end else begin
            next_ce[i] = dec16(ce[i], ctrl[i].bcd);
          end
          next_trig_smp[i] = 1'b0;
        end else if (load_pend[i]) begin
          next_ce[i] = cil[i];
          next_nullc[i] = 1'b0;
          next_load_pend[i] = 1'b0;
        end else if (gate_smp[i]) begin
          next_ce[i] = dec16(ce[i], ctrl[i].bcd);
          if (ce[i] == 16'h0001) begin
            next_outp[i] = 1'b1;
          end
        end
      end

      // host read of a counter port
      if (io_rd && io_addr == 2'(i)) begin
        if (st_held[i]) begin
          next_rdata = st_lat[i];
          next_st_held[i] = 1'b0;
        end else begin
          unique case (rd_st[i])
            ICL_RD_HIGH: begin
              next_rdata = ol[i][15:8];
              next_rd_st[i] = ICL_RD_LOW;
              next_ol_held[i] = 1'b0;
            end
            default: begin
              if (ctrl[i].rw == `ICL_RW_MSB) begin
                next_rdata = ol[i][15:8];
                next_ol_held[i] = 1'b0;
              end else begin
                next_rdata = ol[i][7:0];
                if (ctrl[i].rw == `ICL_RW_WORD) begin
                  next_rd_st[i] = ICL_RD_HIGH;
                end else begin
                  next_ol_held[i] = 1'b0;
                end
              end
            end
          endcase
        end
      end

      // host write of a count byte
      if (io_wr && io_addr == 2'(i)) begin
        next_nullc[i] = 1'b1;
        unique case (ctrl[i].rw)
          `ICL_RW_LSB: begin
            next_cil[i] = {8'h00, io_wdata};
            next_load_pend[i] = 1'b1;
          end
          `ICL_RW_MSB: begin
            next_cil[i] = {io_wdata, 8'h00};
            next_load_pend[i] = 1'b1;
          end
          default: begin
            if (!wr_low_done[i]) begin
              next_cil[i][7:0] = io_wdata;
              next_wr_low_done[i] = 1'b1;
            end else begin
              next_cil[i][15:8] = io_wdata;
              next_wr_low_done[i] = 1'b0;
              next_load_pend[i] = 1'b1;
            end
          end
        endcase
        if (ctrl[i].mode == `ICL_MODE_IOC) begin
          next_outp[i] = 1'b0;
        end
      end

      // control port: latch, read-back or control word
      if (ctrl_wr) begin
        if (is_rb) begin
          if (rb_mask[i]) begin
            if (!io_wdata[`ICL_RB_COUNT_N] && !ol_held[i]) begin
              next_ol[i] = ce[i];
              next_ol_held[i] = 1'b1;
            end
            if (!io_wdata[`ICL_RB_STATUS_N] && !st_held[i]) begin
              next_st_lat[i] = status_byte(outp[i], nullc[i], ctrl[i]);
              next_st_held[i] = 1'b1;
            end
          end
        end else if (sel == 2'(i)) begin
          if (io_wdata[`ICL_RW_HI:`ICL_RW_LO] == `ICL_RW_LATCH) begin
            if (!ol_held[i]) begin
              next_ol[i] = ce[i];
              next_ol_held[i] = 1'b1;
            end
          end else begin
            next_ctrl[i] = io_wdata[5:0];
            next_nullc[i] = 1'b1;
            next_ol_held[i] = 1'b0;
            next_st_held[i] = 1'b0;
            next_rd_st[i] = ICL_RD_TRANSP;
            next_wr_low_done[i] = 1'b0;
            next_load_pend[i] = 1'b0;
            next_armed[i] = 1'b0;
            next_outp[i] = (io_wdata[3:1] != `ICL_MODE_IOC);
          end
        end
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_d <= 1'b0;
      io_rdata <= 8'h00;
      counter_output_pin <= 3'h0;
      ol_held <= '0;
      st_held <= '0;
      wr_low_done <= '0;
      load_pend <= '0;
      armed <= '0;
      nullc <= '0;
      outp <= '0;
      trig <= '0;
      trig_smp <= '0;
      gate_d <= '0;
      gate_smp <= '0;
      for (int i = 0; i < N; i++) begin
        ctrl[i] <= '0;
        ce[i] <= 16'h0000;
        cil[i] <= 16'h0000;
        ol[i] <= 16'h0000;
        st_lat[i] <= 8'h00;
        rd_st[i] <= ICL_RD_TRANSP;
      end
    end else begin
      tick_d <= next_tick_d;
      io_rdata <= next_rdata;
      counter_output_pin <= next_outp;
      ol_held <= next_ol_held;
      st_held <= next_st_held;
      wr_low_done <= next_wr_low_done;
      load_pend <= next_load_pend;
      armed <= next_armed;
      nullc <= next_nullc;
      outp <= next_outp;
      trig <= next_trig;
      trig_smp <= next_trig_smp;
      gate_d <= next_gate_d;
      gate_smp <= next_gate_smp;
      for (int i = 0; i < N; i++) begin
        ctrl[i] <= next_ctrl[i];
        ce[i] <= next_ce[i];
        cil[i] <= next_cil[i];
        ol[i] <= next_ol[i];
        st_lat[i] <= next_st_lat[i];
        rd_st[i] <= next_rd_st[i];
      end
    end
  end
endmodule
`default_nettype wire

// *** test/icl_host_model.sv ***
// host cpu model for the counter i/o port
`timescale 1ns/1ps
`default_nettype none
module icl_host_model (
  input wire logic core_clk,
  output logic [1:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial begin
    io_addr = 2'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // released data is inverted so nothing stale looks valid
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1 io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(posedge core_clk);
    #1 io_wr = 1'b0;
    io_wdata = ~v;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #1 io_addr = a;
    io_rd = 1'b1;
    @(posedge core_clk);
    #1 io_rd = 1'b0;
    v = io_rdata;
  endtask
endmodule
`default_nettype wire

// *** test/icl_timer_checker.sv ***
// concurrent checks on the interval counter ports
`timescale 1ns/1ps
`default_nettype none
module icl_timer_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic timer_tick_input,
  input wire logic [2:0] counter_gate_input,
  input wire logic [2:0] counter_output_pin
);
  // ****
  // control shadow of counter 0
  // ****
  logic ctl_wr;
  logic [5:0] ctl0;
  logic [5:0] next_ctl0;
  always_comb begin
    ctl_wr = io_wr && io_addr == 2'h3 && io_wdata[7:6] != 2'h3 && io_wdata[5:4] != 2'h0;
    next_ctl0 = (ctl_wr && io_wdata[7:6] == 2'h0) ? io_wdata[5:0] : ctl0;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl0 <= 6'h00;
    end else begin
      ctl0 <= next_ctl0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // properties
  // ****
  sequence s_stat_rd;
    io_wr && io_addr == 2'h3 && io_wdata == 8'he2 ##2 io_rd && io_addr == 2'h0;
  endsequence
  property p_mode0_low;
    ctl_wr && io_wdata[7:6] == 2'h0 && io_wdata[3:1] == 3'h0 |=> !counter_output_pin[0];
  endproperty
  property p_c2_mode0_low;
    ctl_wr && io_wdata[7:6] == 2'h2 && io_wdata[3:1] == 3'h0 |=> !counter_output_pin[2];
  endproperty
  property p_mode1_high;
    ctl_wr && io_wdata[7:6] == 2'h1 && io_wdata[3:1] == 3'h1 |=> counter_output_pin[1];
  endproperty
  property p_mode0_no_fall;
    ctl0[3:1] == 3'h0 && $fell(counter_output_pin[0]) |-> $past(io_wr);
  endproperty
  // without a write, outputs may only move while the tick sits low after its fall
  property p_tick_paced;
    !$past(io_wr) && !$past(io_wr, 2) && $changed(counter_output_pin) |-> !$past(timer_tick_input);
  endproperty
  property p_rdata_holds;
    (!io_rd) [*2] |-> $stable(io_rdata);
  endproperty
  property p_status_fields;
    s_stat_rd |=> io_rdata[5:0] == ctl0 && io_rdata[7] == $past(counter_output_pin[0], 3);
  endproperty
  property p_null_set;
    ctl_wr && io_wdata[7:6] == 2'h0 ##2 s_stat_rd |=> io_rdata[6];
  endproperty
  a_mode0_low: assert property (p_mode0_low) else $error("output 0 high after mode 0 setup");
  a_c2_mode0_low: assert property (p_c2_mode0_low) else $error("output 2 high after setup");
  a_mode1_high: assert property (p_mode1_high) else $error("output 1 low after mode 1 setup");
  a_mode0_no_fall: assert property (p_mode0_no_fall) else $error("output 0 fell unprompted");
  a_tick_paced: assert property (p_tick_paced) else $error("output moved off a tick");
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
  a_status_fields: assert property (p_status_fields) else $error("status fields wrong");
  a_null_set: assert property (p_null_set) else $error("null count not set");
endmodule
bind icl_timer icl_timer_checker icl_timer_checker_inst (.core_clk, .reset_n, .io_addr, .io_wr,
  .io_rd, .io_wdata, .io_rdata, .timer_tick_input, .counter_gate_input, .counter_output_pin);
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the interval counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic timer_tick_input = 1'b0;
  logic [2:0] counter_gate_input = 3'h0;
  wire [1:0] io_addr;
  wire io_wr;
  wire io_rd;
  wire [7:0] io_wdata;
  wire [7:0] io_rdata;
  wire [2:0] counter_output_pin;
  logic [7:0] d;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  always #50 core_clk = ~core_clk;
  icl_host_model icl_host_model_inst (.core_clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);
  icl_timer icl_timer_inst (.core_clk, .reset_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .timer_tick_input, .counter_gate_input, .counter_output_pin);
  // ****
  // helpers
  // ****
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic w(input logic [1:0] a, input logic [7:0] v);
    icl_host_model_inst.wr(a, v);
  endtask
  task automatic r(input logic [1:0] a, input logic [7:0] exp, input string nm);
    icl_host_model_inst.rd(a, d);
    chk(nm, d, exp);
  endtask
  task automatic pin(input int i, input logic e);
    chk("output pin", {7'h00, counter_output_pin[i]}, {7'h00, e});
  endtask
  // slow ticks leave room for the sample-then-act pipeline
  task automatic tick(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      #1 timer_tick_input = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 timer_tick_input = 1'b0;
    end
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic trig();
    counter_gate_input[1] = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 counter_gate_input[1] = 1'b1;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1'b1;
    w(2'h3, 8'h30);
    pin(0, 1'b0);
    w(2'h3, 8'hb2);
    pin(2, 1'b1);
    w(2'h3, 8'hb0);
    pin(2, 1'b0);
    w(2'h0, 8'h03);
    w(2'h0, 8'h00);
    counter_gate_input = 3'h1;
    tick(3);
    pin(0, 1'b0);
    tick(1);
    pin(0, 1'b1);
    tick(2);
    pin(0, 1'b1);
    w(2'h0, 8'h10);
    w(2'h0, 8'h00);
    pin(0, 1'b0);
    tick(3);
    w(2'h3, 8'h05);
    tick(1);
    w(2'h3, 8'h0f);
    r(2'h0, 8'h0e, "latched lsb");
    r(2'h0, 8'h00, "latched msb");
    r(2'h0, 8'h0d, "live lsb");
    r(2'h0, 8'h00, "live msb");
    counter_gate_input = 3'h0;
    w(2'h0, 8'h05);
    w(2'h0, 8'h00);
    tick(3);
    r(2'h0, 8'h05, "gated load lsb");
    r(2'h0, 8'h00, "gated load msb");
    counter_gate_input = 3'h1;
    tick(4);
    pin(0, 1'b0);
    tick(1);
    pin(0, 1'b1);
    w(2'h3, 8'h72);
    pin(1, 1'b1);
    w(2'h1, 8'h04);
    w(2'h1, 8'h00);
    w(2'h3, 8'hc6);
    tick(1);
    w(2'h3, 8'hc2);
    r(2'h0, 8'hb0, "status 0");
    r(2'h0, 8'h00, "count 0 lsb");
    r(2'h0, 8'h00, "count 0 msb");
    r(2'h1, 8'hf2, "status 1");
    r(2'h1, 8'h00, "count 1 lsb");
    r(2'h1, 8'h00, "count 1 msb");
    trig();
    tick(1);
    pin(1, 1'b0);
    tick(3);
    pin(1, 1'b0);
    tick(1);
    pin(1, 1'b1);
    trig();
    tick(2);
    w(2'h1, 8'h06);
    w(2'h1, 8'h00);
    tick(1);
    pin(1, 1'b0);
    trig();
    tick(6);
    pin(1, 1'b0);
    tick(1);
    pin(1, 1'b1);
    // decimal counting: ten steps down to nine, not to fifteen
    counter_gate_input[2] = 1'b1;
    w(2'h3, 8'hb1);
    w(2'h2, 8'h10);
    w(2'h2, 8'h00);
    tick(3);
    r(2'h2, 8'h08, "bcd lsb");
    r(2'h2, 8'h00, "bcd msb");
    w(2'h3, 8'h30);
    w(2'h3, 8'he2);
    r(2'h0, 8'h70, "fresh status");
    complete_run();
  end
endmodule
`default_nettype wire
